// *** hdl/nfc_ctrl.sv ***
// nfc host controller core: register set and flash strobe sequencer
`timescale 1ns/10ps
module nfc_ctrl (
  input  logic                 mclk,
  input  logic                 reset,
  input  logic [7:0]           s_axi_awaddr,
  input  logic                 s_axi_awvalid,
  output logic                 s_axi_awready,
  input  logic [31:0]          s_axi_wdata,
  input  logic [3:0]           s_axi_wstrb,
  input  logic                 s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  logic                 s_axi_bready,
  input  logic [7:0]           s_axi_araddr,
  input  logic                 s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  logic                 s_axi_rready,
  output nfc_pkg::nfc_strobe_t strobes,
  input  logic [7:0]           io_bus_in,
  output logic [7:0]           io_bus_out,
  output logic                 io_bus_oe_n,
  input  logic                 ready_busy_n
);
  typedef struct packed {
    nfc_pkg::nfc_state_t st;
    logic [7:0]          cnt;
    logic [1:0]          aIdx;
    logic [2:0]          op;
    logic [7:0]          opByte;
    logic [7:0]          outByte;
    logic                cle;
    logic                ale;
    logic                wst;
    logic                rdStb;
    logic                oeN;
    logic                csN;
    logic                guard;
    logic                csHold;
    logic [23:0]         addr;
    logic [7:0]          rdByte;
    logic [7:0]          statByte;
    logic                refused;
  } nfc_core_t;

  nfc_core_t           q_r;
  nfc_core_t           q_nxt;
  nfc_pkg::nfc_regwr_t regWr;
  logic [7:0]          rdAddr;
  logic [31:0]         rdData;
  logic [31:0]         statWord;
  logic [31:0]         mergeW;
  logic                startOp;
  logic                setRef;
  logic                clrRef;

  // bit 8 is half_page_select, set by the read command, so it is skipped
  function automatic logic [7:0] addrByte(input logic [23:0] a, input logic [1:0] i);
    case (i)
      2'h0: return a[7:0];
      2'h1: return a[16:9];
      default: return {1'b0, a[23:17]};
    endcase
  endfunction

  function automatic logic busyOk(input logic [7:0] b);
    return (b == nfc_pkg::CMD_RESET) || (b == nfc_pkg::CMD_STATUS);
  endfunction

  nfc_axil nfc_axil_i (
    .mclk          (mclk),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .regWr         (regWr),
    .rdAddr        (rdAddr),
    .rdData        (rdData)
  );

  // status view; pass/fail only counts when the device says ready
  always_comb
  begin
    statWord = 32'h0000_0000;
    statWord[nfc_pkg::SR_OPBUSY] = (q_r.st != nfc_pkg::ST_IDLE);
    statWord[nfc_pkg::SR_DEVRDY] = ready_busy_n;
    statWord[nfc_pkg::SR_REFUSED] = q_r.refused;
    statWord[nfc_pkg::SR_PFVALID] = q_r.statByte[nfc_pkg::SB_READY];
    statWord[nfc_pkg::SR_FAIL] = q_r.statByte[nfc_pkg::SB_FAIL]
                               & q_r.statByte[nfc_pkg::SB_READY];
    statWord[nfc_pkg::SR_UNPROT] = q_r.statByte[nfc_pkg::SB_UNPROT];
    statWord[nfc_pkg::SR_RDBYTE +: 8] = q_r.rdByte;
    statWord[nfc_pkg::SR_STBYTE +: 8] = q_r.statByte;
  end

  always_comb
  begin
    case (rdAddr)
      nfc_pkg::REG_CTRL: rdData = {30'h0000_0000, q_r.csHold, q_r.guard};
      nfc_pkg::REG_ADDR: rdData = {8'h00, q_r.addr};
      nfc_pkg::REG_OP:   rdData = {21'h00_0000, q_r.op, q_r.opByte};
      nfc_pkg::REG_STAT: rdData = statWord;
      default:           rdData = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    q_nxt = q_r;
    startOp = 1'b0;
    setRef = 1'b0;
    clrRef = 1'b0;
    mergeW = 32'h0000_0000;
    if (regWr.en)
    begin
      case (regWr.addr)
        nfc_pkg::REG_CTRL:
        begin
          mergeW = nfc_pkg::mergeStrb({30'h0000_0000, q_r.csHold, q_r.guard},
                                      regWr.data, regWr.strb);
          q_nxt.guard = mergeW[nfc_pkg::CTRL_GUARD];
          q_nxt.csHold = mergeW[nfc_pkg::CTRL_CSHLD];
        end
        nfc_pkg::REG_ADDR:
        begin
          mergeW = nfc_pkg::mergeStrb({8'h00, q_r.addr}, regWr.data, regWr.strb);
          q_nxt.addr = mergeW[23:0];
        end
        nfc_pkg::REG_OP:
        begin
          if (q_r.st != nfc_pkg::ST_IDLE)
            setRef = 1'b1;
          else
          begin
            mergeW = nfc_pkg::mergeStrb({21'h00_0000, q_r.op, q_r.opByte},
                                        regWr.data, regWr.strb);
            q_nxt.opByte = mergeW[7:0];
            q_nxt.op = mergeW[nfc_pkg::OP_KIND_LSB +: 3];
            startOp = 1'b1;
          end
        end
        nfc_pkg::REG_STAT:
          clrRef = regWr.strb[0] && regWr.data[nfc_pkg::SR_REFUSED];
        default: ;
      endcase
    end

    case (q_r.st)
      nfc_pkg::ST_IDLE:
      begin
        if (startOp)
        begin
          if (q_nxt.op == nfc_pkg::OP_CMD && !ready_busy_n && !busyOk(q_nxt.opByte))
            setRef = 1'b1;
          else if (q_nxt.op == nfc_pkg::OP_WDATA && !q_r.guard)
            setRef = 1'b1;
          else if (q_nxt.op > nfc_pkg::OP_STATUS)
            setRef = 1'b1;
          else if (q_nxt.op == nfc_pkg::OP_RDATA)
          begin
            q_nxt.st = nfc_pkg::ST_RWAIT;
            q_nxt.cnt = nfc_pkg::RR_CYC - 8'h01;
          end
          else
          begin
            q_nxt.st = nfc_pkg::ST_SETUP;
            q_nxt.aIdx = 2'h0;
            q_nxt.oeN = 1'b0;
            q_nxt.cle = (q_nxt.op == nfc_pkg::OP_CMD) || (q_nxt.op == nfc_pkg::OP_STATUS);
            q_nxt.ale = (q_nxt.op == nfc_pkg::OP_ADDR);
            if (q_nxt.op == nfc_pkg::OP_STATUS)
              q_nxt.outByte = nfc_pkg::CMD_STATUS;
            else if (q_nxt.op == nfc_pkg::OP_ADDR)
              q_nxt.outByte = addrByte(q_r.addr, 2'h0);
            else
              q_nxt.outByte = q_nxt.opByte;
          end
        end
      end
      nfc_pkg::ST_SETUP:
      begin
        q_nxt.wst = 1'b0;
        q_nxt.cnt = nfc_pkg::WLO_CYC - 8'h01;
        q_nxt.st = nfc_pkg::ST_WLOW;
      end
      nfc_pkg::ST_WLOW:
      begin
        if (q_r.cnt != 8'h00)
          q_nxt.cnt = q_r.cnt - 8'h01;
        else
        begin
          q_nxt.wst = 1'b1;
          q_nxt.cnt = nfc_pkg::WHI_CYC - 8'h01;
          q_nxt.st = nfc_pkg::ST_WHIGH;
        end
      end
      nfc_pkg::ST_WHIGH:
      begin
        if (q_r.cnt != 8'h00)
          q_nxt.cnt = q_r.cnt - 8'h01;
        else if (q_r.op == nfc_pkg::OP_ADDR && q_r.aIdx != 2'h2)
        begin
          q_nxt.aIdx = q_r.aIdx + 2'h1;
          q_nxt.outByte = addrByte(q_r.addr, q_r.aIdx + 2'h1);
          q_nxt.wst = 1'b0;
          q_nxt.cnt = nfc_pkg::WLO_CYC - 8'h01;
          q_nxt.st = nfc_pkg::ST_WLOW;
        end
        else
        begin
          q_nxt.cle = 1'b0;
          q_nxt.ale = 1'b0;
          q_nxt.oeN = 1'b1;
          if (q_r.op == nfc_pkg::OP_WDATA)
            q_nxt.st = nfc_pkg::ST_IDLE;
          else
          begin
            // let the device reach busy before anyone looks at ready
            q_nxt.st = nfc_pkg::ST_GAP;
            q_nxt.cnt = (q_r.op == nfc_pkg::OP_STATUS) ? nfc_pkg::WHR_CYC - 8'h01
                                                       : nfc_pkg::WB_CYC - 8'h01;
          end
        end
      end
      nfc_pkg::ST_GAP:
      begin
        if (q_r.cnt != 8'h00)
          q_nxt.cnt = q_r.cnt - 8'h01;
        else if (q_r.op == nfc_pkg::OP_STATUS)
        begin
          q_nxt.rdStb = 1'b0;
          q_nxt.cnt = nfc_pkg::RLO_CYC - 8'h01;
          q_nxt.st = nfc_pkg::ST_RLOW;
        end
        else
          q_nxt.st = nfc_pkg::ST_IDLE;
      end
      nfc_pkg::ST_RWAIT:
      begin
        if (!ready_busy_n)
          q_nxt.cnt = nfc_pkg::RR_CYC - 8'h01;
        else if (q_r.cnt != 8'h00)
          q_nxt.cnt = q_r.cnt - 8'h01;
        else
        begin
          q_nxt.rdStb = 1'b0;
          q_nxt.cnt = nfc_pkg::RLO_CYC - 8'h01;
          q_nxt.st = nfc_pkg::ST_RLOW;
        end
      end
      nfc_pkg::ST_RLOW:
      begin
        if (q_r.cnt != 8'h00)
          q_nxt.cnt = q_r.cnt - 8'h01;
        else
        begin
          if (q_r.op == nfc_pkg::OP_STATUS)
            q_nxt.statByte = io_bus_in;
          else
            q_nxt.rdByte = io_bus_in;
          q_nxt.rdStb = 1'b1;
          q_nxt.cnt = nfc_pkg::RHI_CYC - 8'h01;
          q_nxt.st = nfc_pkg::ST_RHIGH;
        end
      end
      nfc_pkg::ST_RHIGH:
      begin
        if (q_r.cnt != 8'h00)
          q_nxt.cnt = q_r.cnt - 8'h01;
        else
          q_nxt.st = nfc_pkg::ST_IDLE;
      end
      default: q_nxt.st = nfc_pkg::ST_IDLE;
    endcase

    q_nxt.refused = (q_r.refused & ~clrRef) | setRef;
    // chip select released when idle and csHold is clear lets the device drop to standby
    q_nxt.csN = !(q_nxt.csHold || q_nxt.st != nfc_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q_r <= '0;
      q_r.wst <= 1'b1;
      q_r.rdStb <= 1'b1;
      q_r.oeN <= 1'b1;
      q_r.csN <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  assign strobes.cmdLatch = q_r.cle;
  assign strobes.addrLatch = q_r.ale;
  assign strobes.chipSel_n = q_r.csN;
  assign strobes.writeStrobe_n = q_r.wst;
  assign strobes.read_strobe_n = q_r.rdStb;
  assign strobes.writeGuard_n = q_r.guard;
  assign io_bus_out = q_r.outByte;
  assign io_bus_oe_n = q_r.oeN;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_THIRD_MSB_LOW: assert property ((q_r.ale && q_r.aIdx == 2'h2 && !q_r.wst) |-> !io_bus_out[7])
    else $error("third address byte has bit 7 high");
  AST_ADDR_THREE: assert property ($fell(q_r.ale) |-> $past(q_r.aIdx) == 2'h2)
    else $error("address phase ended before three cycles");
  AST_STROBE_CS: assert property ((!q_r.wst || !q_r.rdStb) |-> !q_r.csN)
    else $error("strobe active with chip select high");
  AST_LATCH_EXCL: assert property (!q_r.wst |-> !(q_r.cle && q_r.ale))
    else $error("both latch strobes high during write");
  AST_DATA_GUARD: assert property ((!q_r.wst && !q_r.cle && !q_r.ale) |-> q_r.guard)
    else $error("data written with write guard low");
  AST_BUSY_REFUSE: assert property ((startOp && q_nxt.op == nfc_pkg::OP_CMD && !ready_busy_n
                                     && !busyOk(q_nxt.opByte))
                                    |=> (q_r.st == nfc_pkg::ST_IDLE && q_r.refused))
    else $error("command sent to busy device");
  AST_WLOW_WIDTH: assert property ($fell(q_r.wst) |-> (!q_r.wst)[*7] ##1 q_r.wst)
    else $error("write strobe low time wrong");
  AST_WB_GAP: assert property (($fell(q_r.cle) && q_r.op == nfc_pkg::OP_CMD)
                               |-> ##49 q_r.st == nfc_pkg::ST_GAP ##1 q_r.st == nfc_pkg::ST_IDLE)
    else $error("busy settle wait wrong length");
  AST_READ_HIZ: assert property (!q_r.rdStb |-> q_r.oeN)
    else $error("host drives bus while reading");
  AST_STATUS_CAPTURE: assert property ($changed(q_r.statByte)
                                       |-> $past(q_r.op) == nfc_pkg::OP_STATUS
                                           && $past(q_r.st) == nfc_pkg::ST_RLOW)
    else $error("status byte changed outside status read");
  AST_PF_GATE: assert property ((q_r.statByte[0] && !q_r.statByte[6]) |-> !statWord[4])
    else $error("fail reported while busy");
endmodule

// *** hdl/nfc_pkg.sv ***
// nfc package: register map, carrier types, command codes and timing counts
package nfc_pkg;
  localparam int MCLK_NS = 4;
  localparam int WP_NS   = 25;
  localparam int WH_NS   = 15;
  localparam int WC_NS   = 50;
  localparam int RP_NS   = 35;
  localparam int REH_NS  = 15;
  localparam int RC_NS   = 50;
  localparam int WHR_NS  = 30;
  localparam int WB_NS   = 200;
  localparam int RR_NS   = 20;

  function automatic int toCyc(input int ns);
    return (ns + MCLK_NS - 1) / MCLK_NS;
  endfunction

  function automatic int maxOf(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam logic [7:0] WLO_CYC = 8'(toCyc(WP_NS));
  localparam logic [7:0] WHI_CYC = 8'(maxOf(toCyc(WH_NS), toCyc(WC_NS) - toCyc(WP_NS)));
  localparam logic [7:0] RLO_CYC = 8'(toCyc(RP_NS));
  localparam logic [7:0] RHI_CYC = 8'(maxOf(toCyc(REH_NS), toCyc(RC_NS) - toCyc(RP_NS)));
  localparam logic [7:0] WHR_CYC = 8'(toCyc(WHR_NS));
  localparam logic [7:0] WB_CYC  = 8'(toCyc(WB_NS));
  localparam logic [7:0] RR_CYC  = 8'(toCyc(RR_NS));

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_OP   = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;

  localparam int CTRL_GUARD = 0;
  localparam int CTRL_CSHLD = 1;
  localparam int OP_KIND_LSB = 8;
  localparam int SR_OPBUSY = 0;
  localparam int SR_DEVRDY = 1;
  localparam int SR_REFUSED = 2;
  localparam int SR_PFVALID = 3;
  localparam int SR_FAIL = 4;
  localparam int SR_UNPROT = 5;
  localparam int SR_RDBYTE = 8;
  localparam int SR_STBYTE = 16;
  localparam int SB_FAIL = 0;
  localparam int SB_READY = 6;
  localparam int SB_UNPROT = 7;

  localparam logic [2:0] OP_CMD    = 3'h0;
  localparam logic [2:0] OP_ADDR   = 3'h1;
  localparam logic [2:0] OP_WDATA  = 3'h2;
  localparam logic [2:0] OP_RDATA  = 3'h3;
  localparam logic [2:0] OP_STATUS = 3'h4;

  localparam logic [7:0] CMD_READ1   = 8'h00;
  localparam logic [7:0] CMD_READ2   = 8'h01;
  localparam logic [7:0] CMD_READ3   = 8'h50;
  localparam logic [7:0] CMD_SERIAL  = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'h10;
  localparam logic [7:0] CMD_ERASE1  = 8'h60;
  localparam logic [7:0] CMD_ERASE2  = 8'hD0;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_IDREAD  = 8'h90;
  localparam logic [7:0] CMD_RESET   = 8'hFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_WLOW, ST_WHIGH, ST_GAP, ST_RWAIT, ST_RLOW, ST_RHIGH
  } nfc_state_t;

  typedef struct packed {
    logic cmdLatch;
    logic addrLatch;
    logic chipSel_n;
    logic writeStrobe_n;
    logic read_strobe_n;
    logic writeGuard_n;
  } nfc_strobe_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } nfc_regwr_t;

  typedef struct packed {
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    nfc_regwr_t  wr;
  } nfc_axis_t;

  function automatic logic isMapped(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_OP) || (a == REG_STAT);
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction
endpackage

// *** hdl/nfc_axil.sv ***
// nfc AXI4-Lite slave: handshakes, write pulse toward the core, read capture
`timescale 1ns/10ps
module nfc_axil (
  input  logic                mclk,
  input  logic                reset,
  input  logic [7:0]          s_axi_awaddr,
  input  logic                s_axi_awvalid,
  output logic                s_axi_awready,
  input  logic [31:0]         s_axi_wdata,
  input  logic [3:0]          s_axi_wstrb,
  input  logic                s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  logic                s_axi_bready,
  input  logic [7:0]          s_axi_araddr,
  input  logic                s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  logic                s_axi_rready,
  output nfc_pkg::nfc_regwr_t regWr,
  output logic [7:0]          rdAddr,
  input  logic [31:0]         rdData
);
  nfc_pkg::nfc_axis_t q_r;
  nfc_pkg::nfc_axis_t q_nxt;

  assign s_axi_awready = !q_r.awHeld && !q_r.bvalid;
  assign s_axi_wready  = !q_r.wHeld && !q_r.bvalid;
  assign s_axi_arready = !q_r.rvalid;
  assign s_axi_bvalid  = q_r.bvalid;
  assign s_axi_bresp   = q_r.bresp;
  assign s_axi_rvalid  = q_r.rvalid;
  assign s_axi_rresp   = q_r.rresp;
  assign s_axi_rdata   = q_r.rdata;
  assign regWr         = q_r.wr;
  assign rdAddr        = s_axi_araddr;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.wr.en = 1'b0;
    // address and data may come in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      q_nxt.awHeld = 1'b1;
      q_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      q_nxt.wHeld = 1'b1;
      q_nxt.wData = s_axi_wdata;
      q_nxt.wStrb = s_axi_wstrb;
    end
    if (q_r.awHeld && q_r.wHeld && !q_r.bvalid)
    begin
      q_nxt.awHeld = 1'b0;
      q_nxt.wHeld = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.wr.en = nfc_pkg::isMapped(q_r.awAddr);
      q_nxt.wr.addr = q_r.awAddr;
      q_nxt.wr.data = q_r.wData;
      q_nxt.wr.strb = q_r.wStrb;
      q_nxt.bresp = nfc_pkg::isMapped(q_r.awAddr) ? nfc_pkg::RESP_OKAY : nfc_pkg::RESP_SLVERR;
    end
    if (q_r.bvalid && s_axi_bready)
      q_nxt.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rdata = nfc_pkg::isMapped(s_axi_araddr) ? rdData : 32'h0000_0000;
      q_nxt.rresp = nfc_pkg::isMapped(s_axi_araddr) ? nfc_pkg::RESP_OKAY : nfc_pkg::RESP_SLVERR;
    end
    if (q_r.rvalid && s_axi_rready)
      q_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end
endmodule

// *** testbench/nfc_flash_model.sv ***
// flash device model: latches, read pointer, status byte, busy timing
`timescale 1ns/10ps
module nfc_flash_model (
  input  wire logic                 mclk,
  input  wire nfc_pkg::nfc_strobe_t strb,
  input  wire logic [7:0]           busIn,
  output logic [7:0]                devOut,
  output logic                      devDrive,
  output logic                      readyBusy_n
);
  logic       wsOld = 1'b1;
  logic       rsOld = 1'b1;
  logic       stMode = 1'b0;
  logic       half = 1'b0;
  logic [7:0] cmd = 8'hFF;
  logic [1:0] acnt = 2'h0;
  logic [9:0] ptr = 10'h000;
  int         busy = 0;
  wire        sel = !strb.chipSel_n;
  wire        wsRise = sel && !wsOld && strb.writeStrobe_n;
  assign readyBusy_n = (busy == 0);
  assign devDrive = sel && !strb.read_strobe_n;
  always @(posedge mclk)
  begin
    wsOld <= strb.writeStrobe_n;
    rsOld <= strb.read_strobe_n;
    if (busy > 0)
      busy <= busy - 1;
    if (wsRise && strb.cmdLatch && (busy == 0 || busIn == 8'hFF || busIn == 8'h70))
    begin
      cmd <= busIn;
      acnt <= 2'h0;
      stMode <= (busIn == 8'h70);
      if (busIn == 8'h00 || busIn == 8'h01)
        half <= busIn[0];
      if (strb.writeGuard_n && (busIn == 8'h10 || (busIn == 8'hD0 && cmd == 8'h60)))
        busy <= 400;
    end
    else if (wsRise && strb.addrLatch)
    begin
      acnt <= acnt + 2'h1;
      if (acnt == 2'h0)
        ptr <= (cmd == 8'h50) ? {6'h20, busIn[3:0]} : {1'b0, half, busIn};
      if (acnt == 2'h2 && (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50))
        busy <= 20;
    end
    if (sel && rsOld && !strb.read_strobe_n)
    begin
      devOut <= stMode ? {strb.writeGuard_n, busy == 0, 6'h00}
                       : ptr[7:0] ^ {6'h00, ptr[9:8]} ^ 8'h5A;
      ptr <= ptr + 10'h001;
    end
  end
endmodule

// *** testbench/nfc_ctrl_bench.sv ***
// bench: register tasks over the host bus, flash sequences and checks
`timescale 1ns/10ps
module nfc_ctrl_bench;
  logic                 mclk = 1'b0;
  logic                 reset = 1'b1;
  logic [7:0]           awaddr = 8'h00;
  logic [7:0]           araddr = 8'h00;
  logic                 awvalid = 1'b0;
  logic                 wvalid = 1'b0;
  logic                 bready = 1'b0;
  logic                 arvalid = 1'b0;
  logic                 rready = 1'b0;
  logic [31:0]          wdata = 32'h0;
  logic                 awready, wready, bvalid, arready, rvalid, devDrive, readyBusy_n, oe_n;
  logic [1:0]           bresp, rresp, rr;
  logic [31:0]          rdata, v;
  logic [7:0]           hostOut, devOut, ioBus;
  logic [7:0]           lastBus = 8'h00;
  nfc_pkg::nfc_strobe_t strb;
  int                   fails = 0;
  int                   checkCount = 0;
  int                   cyc = 0;
  always #2 mclk = ~mclk;
  assign ioBus = !oe_n ? hostOut : devDrive ? devOut : ~lastBus;
  always @(posedge mclk) lastBus <= ioBus;
  nfc_ctrl nfc_ctrl_i (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .strobes(strb), .io_bus_in(ioBus), .io_bus_out(hostOut),
    .io_bus_oe_n(oe_n), .ready_busy_n(readyBusy_n));
  nfc_flash_model nfc_flash_model_i (.mclk(mclk), .strb(strb), .busIn(ioBus), .devOut(devOut),
    .devDrive(devDrive), .readyBusy_n(readyBusy_n));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(negedge mclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(negedge mclk);
      ta = arvalid && arready; tr = rvalid; v = rdata; rr = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic op(input logic [2:0] k, input logic [7:0] b);
    wr(nfc_pkg::REG_OP, {21'h0, k, b});
    do rd(nfc_pkg::REG_STAT); while (v[0] !== 1'b0);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      give_verdict;
    end
  end
  logic [7:0] mc [3] = '{8'h00, 8'h01, 8'h50};
  logic [9:0] p;
  initial
  begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(nfc_pkg::REG_CTRL); chk("ctrl reset", 32'h0, v);
    rd(nfc_pkg::REG_STAT); chk("stat reset", 32'h2, v);
    rd(8'h10); chk("unmapped resp", 32'h2, 32'(rr));
    op(nfc_pkg::OP_STATUS, 8'h00); chk("status protected", 32'h40, 32'(v[23:16]));
    wr(nfc_pkg::REG_CTRL, 32'h1); op(nfc_pkg::OP_STATUS, 8'h00);
    chk("status unprotected", 32'hC0, 32'(v[23:16]));
    $display("test status done");
    for (int i = 0; i < 3; i++)
    begin
      p = (i == 2) ? 10'h20E : {1'b0, i[0], 8'hFE};
      wr(nfc_pkg::REG_ADDR, {24'h0, p[7:0]});
      op(nfc_pkg::OP_CMD, mc[i]); op(nfc_pkg::OP_ADDR, 8'h00);
      op(nfc_pkg::OP_RDATA, 8'h00);
      chk("read byte", 32'(p[7:0] ^ {6'h0, p[9:8]} ^ 8'h5A), 32'(v[15:8]));
      p = p + 10'h1; op(nfc_pkg::OP_RDATA, 8'h00);
      chk("next byte", 32'(p[7:0] ^ {6'h0, p[9:8]} ^ 8'h5A), 32'(v[15:8]));
    end
    $display("test read modes done");
    wr(nfc_pkg::REG_CTRL, 32'h0); op(nfc_pkg::OP_WDATA, 8'h11);
    chk("data in refused", 32'h1, 32'(v[2]));
    wr(nfc_pkg::REG_STAT, 32'h4); rd(nfc_pkg::REG_STAT); chk("refused clear", 32'h0, 32'(v[2]));
    op(nfc_pkg::OP_CMD, 8'h80); op(nfc_pkg::OP_ADDR, 8'h00); op(nfc_pkg::OP_CMD, 8'h10);
    chk("guard blocks program", 32'h1, 32'(v[1]));
    $display("test guard done");
    wr(nfc_pkg::REG_CTRL, 32'h3); rd(nfc_pkg::REG_CTRL); chk("ctrl hold", 32'h3, v);
    chk("cs held idle", 32'h0, 32'(strb.chipSel_n));
    op(nfc_pkg::OP_CMD, 8'h60);
    op(nfc_pkg::OP_ADDR, 8'h00); op(nfc_pkg::OP_CMD, 8'hD0); op(nfc_pkg::OP_STATUS, 8'h00);
    chk("status busy", 32'h80, 32'(v[23:16]));
    chk("pass fail invalid", 32'h0, 32'(v[3]));
    op(nfc_pkg::OP_CMD, 8'h00); chk("busy refusal", 32'h1, 32'(v[2]));
    do rd(nfc_pkg::REG_STAT); while (v[1] !== 1'b1);
    op(nfc_pkg::OP_STATUS, 8'h00); chk("erase pass", 32'h1, 32'(v[4:3]));
    $display("test erase done");
    give_verdict;
  end
endmodule
